// [hdl/ims_link_if.sv]
// Upstream two-wire link between one master end and the slave port.
// Assumes pull-ups: a line is high unless some party enables a low drive.
`timescale 1ns/1ps
`default_nettype none
interface ims_link_if;
	logic mSclO;
	logic mSclOe;
	logic mSdaO;
	logic mSdaOe;
	logic dSdaO;
	logic dSdaOe;
	logic scl;
	logic sda;

	// Wired-AND resolution of the open-drain lines
	assign scl = !(mSclOe && !mSclO);
	assign sda = !((mSdaOe && !mSdaO) || (dSdaOe && !dSdaO));

	modport master (
		output mSclO,
		output mSclOe,
		output mSdaO,
		output mSdaOe,
		input  scl,
		input  sda
	);

	modport dev (
		output dSdaO,
		output dSdaOe,
		input  scl,
		input  sda
	);
endinterface : ims_link_if
`default_nettype wire

// [hdl/ims_master_end.sv]
// Upstream bus master end: one byte slot per request, SCL by divider.
// Assumes the slave never stretches SCL; single master on this bus.
`timescale 1ns/1ps
`default_nettype none
module ims_master_end (
	input  wire logic        clk,
	input  wire logic        rst,
	ims_link_if.master       bus,
	input  wire logic        reqValid,
	output logic             reqReady,
	input  wire logic        reqStart,
	input  wire logic        reqStop,
	input  wire logic        reqRead,
	input  wire logic        reqAckOut,
	input  wire logic [7:0]  reqData,
	output logic             doneValid,
	output logic [7:0]       rdData,
	output logic             ackSeen
);
	typedef enum {MS_IDLE, MS_START, MS_BIT, MS_STOP} ims_mst_e;

	ims_mst_e    state;
	logic        sclM1, sclS, sdaM1, sdaS;
	logic        sclOe, sdaOe, doStop, isRead, ackOut;
	logic [7:0]  shiftReg, qCnt;
	logic [3:0]  bitIdx;
	logic [1:0]  phase;

	// Slot timing decode
	wire qTick   = (qCnt == 8'h00);
	wire ackSlot = (bitIdx == ims_pkg::BITS_PER_BYTE);
	wire busHigh = sclS && sdaS;

	assign bus.mSclO  = 1'b0;
	assign bus.mSdaO  = 1'b0;
	assign bus.mSclOe = sclOe;
	assign bus.mSdaOe = sdaOe;

	// Line synchronisers; first stage feeds only the second
	always_ff @(posedge clk)
	begin
		sclM1 <= bus.scl;
		sclS  <= sclM1;
		sdaM1 <= bus.sda;
		sdaS  <= sdaM1;
	end

	// Byte engine, four quarter phases per bit
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state     <= MS_IDLE;
			sclOe     <= 1'b0;
			sdaOe     <= 1'b0;
			reqReady  <= 1'b0;
			doneValid <= 1'b0;
			rdData    <= 8'h00;
			ackSeen   <= 1'b0;
			shiftReg  <= 8'h00;
			qCnt      <= 8'h00;
			bitIdx    <= 4'h0;
			phase     <= ims_pkg::PH_SETUP;
			{doStop, isRead, ackOut} <= 3'h0;
		end
		else
		begin
			doneValid <= 1'b0;
			qCnt <= qTick ? ims_pkg::QTR_M1 : qCnt - 8'h01;
			if (qTick && state != MS_IDLE)
				phase <= phase + 2'h1;
			case (state)
			MS_IDLE:
			begin
				reqReady <= 1'b1;
				if (reqValid && reqReady)
				begin
					reqReady <= 1'b0;
					shiftReg <= reqData;
					doStop   <= reqStop;
					isRead   <= reqRead;
					ackOut   <= reqAckOut;
					bitIdx   <= 4'h0;
					phase    <= ims_pkg::PH_SETUP;
					qCnt     <= ims_pkg::QTR_M1;
					state    <= reqStart ? MS_START : MS_BIT;
				end
			end
			MS_START:
				if (qTick)
					case (phase)
					ims_pkg::PH_SETUP: sdaOe <= 1'b0;
					ims_pkg::PH_RISE:  sclOe <= 1'b0;
					ims_pkg::PH_SAMPLE:
						if (busHigh)
							sdaOe <= 1'b1;
						else
							phase <= phase; // Wait for an idle bus
					default:
					begin
						sclOe <= 1'b1;
						state <= MS_BIT;
					end
					endcase
			MS_BIT:
				if (qTick)
					case (phase)
					ims_pkg::PH_SETUP:
						if (ackSlot)
							sdaOe <= isRead && ackOut;
						else
							sdaOe <= !isRead && !shiftReg[7];
					ims_pkg::PH_RISE: sclOe <= 1'b0;
					ims_pkg::PH_SAMPLE:
						if (ackSlot)
							ackSeen <= !sdaS;
						else
							shiftReg <= {shiftReg[6:0], sdaS};
					default:
					begin
						sclOe <= 1'b1;
						bitIdx <= bitIdx + 4'h1;
						if (ackSlot)
						begin
							rdData <= shiftReg; // SDA kept
							if (doStop)
								state <= MS_STOP;
							else
							begin
								doneValid <= 1'b1;
								state     <= MS_IDLE;
							end
						end
					end
					endcase
			MS_STOP:
				if (qTick)
					case (phase)
					ims_pkg::PH_SETUP:  sdaOe <= 1'b1;
					ims_pkg::PH_RISE:   sclOe <= 1'b0;
					ims_pkg::PH_SAMPLE: sdaOe <= 1'b0;
					default:
					begin
						doneValid <= 1'b1;
						state     <= MS_IDLE;
					end
					endcase
			default:
				state <= MS_IDLE;
			endcase
		end
	end
endmodule : ims_master_end
`default_nettype wire

// [hdl/ims_pkg.sv]
// Shared constants for the selector slave port and its upstream master.
// Assumes a 100 MHz system clock and a 31.25 MHz link sampling clock.
package ims_pkg;

	// Clock rates and serial bit timing
	localparam int CLK_HZ    = 100_000_000;
	localparam int LINK_HZ   = 31_250_000;
	localparam int SCL_HZ    = 100_000;
	localparam int QTR_CYC   = CLK_HZ / (4 * SCL_HZ);
	localparam int HALF_LCYC = LINK_HZ / (2 * SCL_HZ);
	localparam logic [7:0] QTR_M1  = 8'(QTR_CYC - 1);
	localparam logic [7:0] HALF_M1 = 8'(HALF_LCYC - 1);

	// Slave address, plain default
	localparam logic [6:0] DEV_ADDR = 7'h74;

	// Register indices; reads wrap after the last one
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_AUX  = 2'h1;
	localparam logic [1:0] REG_STAT = 2'h2;
	localparam logic [1:0] REG_LAST = 2'h2;

	// Control fields: select in [1:0], recovery request at bit 2
	localparam int CTRL_REC_BIT = 2;
	localparam int STAT_BUSY_BIT = 2;
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_CH0  = 2'h1;
	localparam logic [1:0] SEL_CH1  = 2'h2;

	// Byte positions inside a write transaction
	localparam logic [1:0] BYTE_ADDR  = 2'h0;
	localparam logic [1:0] BYTE_PTR   = 2'h1;
	localparam logic [1:0] BYTE_DATA  = 2'h2;
	localparam logic [1:0] BYTE_EXTRA = 2'h3;

	// Bit and edge counts
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [4:0] RECOVER_EDGES = 5'h12;

	// Quarter phases of one master bit slot
	localparam logic [1:0] PH_SETUP  = 2'h0;
	localparam logic [1:0] PH_RISE   = 2'h1;
	localparam logic [1:0] PH_SAMPLE = 2'h2;
	localparam logic [1:0] PH_FALL   = 2'h3;

endpackage : ims_pkg

// [hdl/ims_slave_port.sv]
// Upstream slave port of the two-master selector, with recovery burst.
// Assumes linkClk far faster than SCL; rstN is an unsynchronised pin.
`timescale 1ns/1ps
`default_nettype none
module ims_slave_port #(
	parameter logic       DEFAULT_CH0 = 1'b1,
	parameter logic [6:0] ADDR        = ims_pkg::DEV_ADDR
) (
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic  linkClk,
	input  wire logic  rstN,
	ims_link_if.dev    bus,
	output logic       dsSclOe,
	output logic       dsSdaOe,
	output logic       connCh0,
	output logic       connCh1,
	output logic       recoverDone
);
	typedef enum {SS_IDLE, SS_RECV, SS_ACK, SS_SEND, SS_RACK} ims_slv_e;
	typedef enum {RB_IDLE, RB_PULSE, RB_SCLLO, RB_SDALO, RB_SCLHI,
		RB_STOP} ims_rec_e;

	ims_slv_e    state;
	ims_rec_e    rb;
	logic        sclM1, sclS, sclP, sdaM1, sdaS, sdaP;
	logic        rstNM1, rstNS;
	logic        sdaOe, isRead, mAck, recGo, recBusy, recFin, recTgl;
	logic [7:0]  shiftReg, aux, halfCnt;
	logic [3:0]  bitCnt;
	logic [4:0]  edgeCnt;
	logic [1:0]  byteIdx, ptr, sel, pendSel;
	logic        c0M1, c0S, c1M1, c1S, tM1, tS, tP;
	logic        ch0Lvl, ch1Lvl;

	// Wrap the read pointer past the last register
	function automatic logic [1:0] ims_next_ptr(input logic [1:0] p);
		ims_next_ptr = (p >= ims_pkg::REG_LAST) ? ims_pkg::REG_CTRL
			: p + 2'h1;
	endfunction : ims_next_ptr

	// Pin synchronisers; only the second stage reads the first
	always_ff @(posedge linkClk)
	begin
		sclM1  <= bus.scl;
		sclS   <= sclM1;
		sclP   <= sclS;
		sdaM1  <= bus.sda;
		sdaS   <= sdaM1;
		sdaP   <= sdaS;
		rstNM1 <= rstN;
		rstNS  <= rstNM1;
	end

	// Bus conditions decoded from synchronised lines
	wire linkRst   = !rstNS;
	wire sclRise   = sclS && !sclP;
	wire sclFall   = !sclS && sclP;
	wire startCond = sclS && sclP && sdaP && !sdaS;
	wire stopCond  = sclS && sclP && !sdaP && sdaS;
	wire addrHit   = (shiftReg[7:1] == ADDR);
	wire byteDone  = sclFall && (bitCnt == ims_pkg::BITS_PER_BYTE);
	wire wrData    = !isRead && (byteIdx == ims_pkg::BYTE_DATA);
	wire recReq    = shiftReg[ims_pkg::CTRL_REC_BIT];
	wire halfTick  = (halfCnt == 8'h00);
	wire ackNow    = (byteIdx == ims_pkg::BYTE_ADDR) ? addrHit
		: (byteIdx != ims_pkg::BYTE_EXTRA);
	wire [7:0] statWord = {5'h00, recBusy, sel};
	wire [7:0] ctrlWord = {5'h00, 1'b0, sel};
	wire [7:0] rdWord = (ptr == ims_pkg::REG_CTRL) ? ctrlWord
		: (ptr == ims_pkg::REG_AUX) ? aux
		: (ptr == ims_pkg::REG_STAT) ? statWord : 8'h00;

	assign bus.dSdaO  = 1'b0;
	assign bus.dSdaOe = sdaOe;

	// Slave state machine and register writes
	always_ff @(posedge linkClk)
	begin
		if (linkRst)
		begin
			state    <= SS_IDLE;
			sdaOe    <= 1'b0;
			bitCnt   <= 4'h0;
			byteIdx  <= ims_pkg::BYTE_ADDR;
			shiftReg <= 8'h00;
			isRead   <= 1'b0;
			mAck     <= 1'b0;
			ptr      <= ims_pkg::REG_CTRL;
			aux      <= 8'h00;
			recGo    <= 1'b0;
			pendSel  <= ims_pkg::SEL_NONE;
			sel      <= DEFAULT_CH0 ? ims_pkg::SEL_CH0
				: ims_pkg::SEL_NONE;
		end
		else
		begin
			recGo <= 1'b0;
			if (recFin)
				sel <= pendSel; // Reconnect only after the burst
			if (startCond)
			begin
				state   <= SS_RECV;
				sdaOe   <= 1'b0;
				bitCnt  <= 4'h0;
				byteIdx <= ims_pkg::BYTE_ADDR;
				isRead  <= 1'b0;
			end
			else if (stopCond)
			begin
				state <= SS_IDLE;
				sdaOe <= 1'b0;
			end
			else
			begin
				case (state)
				SS_RECV:
				begin
					if (sclRise)
					begin
						shiftReg <= {shiftReg[6:0], sdaS};
						bitCnt   <= bitCnt + 4'h1;
					end
					else if (byteDone)
					begin
						sdaOe <= ackNow;
						state <= SS_ACK;
						if (byteIdx == ims_pkg::BYTE_ADDR)
						begin
							isRead <= shiftReg[0];
							if (!addrHit)
								state <= SS_IDLE;
						end
						if (byteIdx == ims_pkg::BYTE_PTR)
							ptr <= shiftReg[1:0];
						if (byteIdx != ims_pkg::BYTE_EXTRA)
							byteIdx <= byteIdx + 2'h1;
						if (wrData && ptr == ims_pkg::REG_AUX)
							aux <= shiftReg;
						if (wrData && ptr == ims_pkg::REG_CTRL && recReq)
						begin
							sel     <= ims_pkg::SEL_NONE; // Isolate first
							pendSel <= shiftReg[1:0];
							recGo   <= 1'b1;
						end
						else if (wrData && ptr == ims_pkg::REG_CTRL)
							sel <= shiftReg[1:0];
					end
				end
				SS_ACK:
				begin
					// Hold the acknowledge low until SCL falls again
					if (sclFall)
					begin
						bitCnt <= 4'h0;
						sdaOe  <= 1'b0;
						state  <= SS_RECV;
						if (isRead)
						begin
							shiftReg <= rdWord;
							sdaOe    <= !rdWord[7];
							ptr      <= ims_next_ptr(ptr);
							state    <= SS_SEND;
						end
					end
				end
				SS_SEND:
				begin
					if (sclFall && bitCnt == ims_pkg::BITS_PER_BYTE - 4'h1)
					begin
						sdaOe <= 1'b0;
						state <= SS_RACK;
					end
					else if (sclFall)
					begin
						shiftReg <= {shiftReg[6:0], 1'b0};
						sdaOe    <= !shiftReg[6];
						bitCnt   <= bitCnt + 4'h1;
					end
				end
				SS_RACK:
				begin
					if (sclRise)
						mAck <= !sdaS;
					else if (sclFall && mAck)
					begin
						shiftReg <= rdWord;
						sdaOe    <= !rdWord[7];
						ptr      <= ims_next_ptr(ptr);
						bitCnt   <= 4'h0;
						state    <= SS_SEND;
					end
					else if (sclFall)
					begin
						sdaOe <= 1'b0;
						state <= SS_IDLE;
					end
				end
				default:
					sdaOe <= 1'b0;
				endcase
			end
		end
	end

	// Downstream recovery: nine pulses, released SDA, then stop
	always_ff @(posedge linkClk)
	begin
		if (linkRst)
		begin
			rb      <= RB_IDLE;
			dsSclOe <= 1'b0;
			dsSdaOe <= 1'b0;
			edgeCnt <= 5'h00;
			halfCnt <= 8'h00;
			recBusy <= 1'b0;
			recFin  <= 1'b0;
			recTgl  <= 1'b0;
		end
		else
		begin
			recFin  <= 1'b0;
			halfCnt <= halfTick ? ims_pkg::HALF_M1 : halfCnt - 8'h01;
			case (rb)
			RB_IDLE:
				if (recGo)
				begin
					rb      <= RB_PULSE;
					recBusy <= 1'b1;
					edgeCnt <= 5'h00;
					halfCnt <= ims_pkg::HALF_M1;
				end
			RB_PULSE:
				if (halfTick)
				begin
					dsSclOe <= !dsSclOe;
					edgeCnt <= edgeCnt + 5'h01;
					if (edgeCnt == ims_pkg::RECOVER_EDGES - 5'h01)
						rb <= RB_SCLLO;
				end
			RB_SCLLO:
				if (halfTick)
				begin
					dsSclOe <= 1'b1;
					rb      <= RB_SDALO;
				end
			RB_SDALO:
				if (halfTick)
				begin
					dsSdaOe <= 1'b1; // SDA moves only with SCL low
					rb      <= RB_SCLHI;
				end
			RB_SCLHI:
				if (halfTick)
				begin
					dsSclOe <= 1'b0;
					rb      <= RB_STOP;
				end
			RB_STOP:
				if (halfTick)
				begin
					dsSdaOe <= 1'b0; // Stop condition
					recBusy <= 1'b0;
					recFin  <= 1'b1;
					recTgl  <= !recTgl;
					rb      <= RB_IDLE;
				end
			default:
				rb <= RB_IDLE;
			endcase
		end
	end

	// Selection decoded in the link domain so only flops cross over
	always_ff @(posedge linkClk)
	begin
		ch0Lvl <= (sel == ims_pkg::SEL_CH0);
		ch1Lvl <= (sel == ims_pkg::SEL_CH1);
	end

	// Status into the system domain; bits cross as separate levels
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			{c0M1, c0S, c1M1, c1S} <= 4'h0;
			{tM1, tS, tP}          <= 3'h0;
			connCh0     <= 1'b0;
			connCh1     <= 1'b0;
			recoverDone <= 1'b0;
		end
		else
		begin
			c0M1        <= ch0Lvl;
			c0S         <= c0M1;
			c1M1        <= ch1Lvl;
			c1S         <= c1M1;
			tM1         <= recTgl;
			tS          <= tM1;
			tP          <= tS;
			connCh0     <= c0S;
			connCh1     <= c1S;
			recoverDone <= tS ^ tP;
		end
	end
endmodule : ims_slave_port
`default_nettype wire

// [testbench/i2c_master_selector_slave_port_bench.sv]
// Bench: master end and slave port joined on one link, run end to end.
// Assumes the package and link interface are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_selector_slave_port_bench;
	localparam logic [3:0] ST = 4'h8;
	localparam logic [3:0] SP = 4'h4;
	localparam logic [3:0] RD = 4'h2;
	localparam logic [3:0] AK = 4'h1;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       linkClk = 1'b0;
	logic       rstN = 1'b0;
	logic       reqValid = 1'b0;
	logic       reqStart = 1'b0;
	logic       reqStop = 1'b0;
	logic       reqRead = 1'b0;
	logic       reqAckOut = 1'b0;
	logic [7:0] reqData = 8'h00;
	logic       reqReady;
	logic       doneValid;
	logic [7:0] rdData;
	logic       ackSeen;
	logic       dsSclOe;
	logic       dsSdaOe;
	logic       connCh0;
	logic       connCh1;
	logic       recoverDone;
	logic       spareCh0;
	logic       spareCh1;
	logic [7:0] q;
	logic       a;
	logic       pDsScl;
	logic       doneSeen = 1'b0;
	logic [7:0] burst = 8'h00;
	logic [7:0] atDone;
	logic [1:0] linesAtDone;
	int         errorCnt = 0;
	int         cmpCount = 0;
	int         cycles = 0;

	ims_link_if link ();
	ims_link_if spare ();

	// Idle second link: its master side never pulls a line low
	assign spare.mSclO  = 1'b0;
	assign spare.mSclOe = 1'b0;
	assign spare.mSdaO  = 1'b0;
	assign spare.mSdaOe = 1'b0;

	// Link clock offset so its phase never tracks the core clock
	always #5 clk = !clk;
	initial
	begin
		#7;
		forever #16 linkClk = !linkClk;
	end

	ims_slave_port #(.DEFAULT_CH0(1'b1)) ims_slave_port_inst (
		.clk(clk), .rst(rst), .linkClk(linkClk), .rstN(rstN),
		.bus(link.dev), .dsSclOe(dsSclOe), .dsSdaOe(dsSdaOe),
		.connCh0(connCh0), .connCh1(connCh1), .recoverDone(recoverDone)
	);
	// No-channel variant, watched only for isolation after reset and under pin reset
	ims_slave_port #(.DEFAULT_CH0(1'b0)) ims_slave_port_spare_inst (
		.clk(clk), .rst(rst), .linkClk(linkClk), .rstN(rstN),
		.bus(spare.dev), .dsSclOe(), .dsSdaOe(),
		.connCh0(spareCh0), .connCh1(spareCh1), .recoverDone()
	);
	ims_master_end ims_master_end_inst (
		.clk(clk), .rst(rst), .bus(link.master), .reqValid(reqValid),
		.reqReady(reqReady), .reqStart(reqStart), .reqStop(reqStop),
		.reqRead(reqRead), .reqAckOut(reqAckOut), .reqData(reqData),
		.doneValid(doneValid), .rdData(rdData), .ackSeen(ackSeen)
	);
	ims_link_properties ims_link_properties_inst (
		.clk(clk), .rst(rst), .linkClk(linkClk), .rstN(rstN),
		.mSdaOe(link.mSdaOe), .dSdaOe(link.dSdaOe), .scl(link.scl),
		.sda(link.sda)
	);

	task automatic testDone();
		$display("compares %0d, mismatches %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : testDone

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One byte slot; request held until the edge that takes it
	task automatic xfer(input logic [3:0] how, input logic [7:0] d);
		while (reqReady !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		reqValid <= 1'b1;
		{reqStart, reqStop, reqRead, reqAckOut} <= how;
		reqData <= d;
		@(posedge clk);
		reqValid <= 1'b0;
		while (doneValid !== 1'b1)
			@(negedge clk);
		q = rdData;
		a = ackSeen;
	endtask : xfer

	// Recovery runs under the write, so its pulses are logged here
	always @(posedge clk)
	begin
		pDsScl <= dsSclOe;
		if (pDsScl && !dsSclOe && !dsSdaOe)
			burst <= burst + 8'h01;
		if (recoverDone === 1'b1)
		begin
			doneSeen <= 1'b1;
			atDone <= burst;
			linesAtDone <= {dsSclOe, dsSdaOe};
		end
		cycles <= cycles + 1;
		if (cycles == 90000)
		begin
			errorCnt++;
			testDone();
		end
	end

	initial
	begin
		// Both resets long enough for the link synchroniser
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rstN <= 1'b1;
		repeat (12) @(posedge clk);
		check({6'h00, connCh1, connCh0}, 8'h01);
		check({6'h00, dsSclOe, dsSdaOe}, 8'h00);
		check({6'h00, spareCh1, spareCh0}, 8'h00);
		// Control write asking recovery to channel 1, then a refused byte
		xfer(ST, {ims_pkg::DEV_ADDR, 1'b0});
		check({7'h00, a}, 8'h01);
		xfer(4'h0, {6'h00, ims_pkg::REG_CTRL});
		check({7'h00, a}, 8'h01);
		xfer(4'h0, 8'(1 << ims_pkg::CTRL_REC_BIT) | {6'h00, ims_pkg::SEL_CH1});
		check({7'h00, a}, 8'h01);
		xfer(SP, 8'h5A);
		check({7'h00, a}, 8'h00);
		check({6'h00, link.scl, link.sda}, 8'h03);
		// Burst and stop end close together; bounded wait for the burst
		for (int i = 0; i < 4000 && doneSeen !== 1'b1; i++)
			@(posedge clk);
		repeat (8) @(posedge clk);
		check({7'h00, doneSeen}, 8'h01);
		check(atDone, 8'h09);
		check({6'h00, linesAtDone}, 8'h00);
		check({6'h00, connCh1, connCh0}, 8'h02);
		// Four reads from index 0: the last one wraps round
		xfer(ST, {ims_pkg::DEV_ADDR, 1'b1});
		check({7'h00, a}, 8'h01);
		xfer(RD | AK, 8'hFF);
		check(q, {6'h00, ims_pkg::SEL_CH1});
		xfer(RD | AK, 8'hFF);
		check(q, 8'h00);
		xfer(RD | AK, 8'hFF);
		check(q, {6'h00, ims_pkg::SEL_CH1});
		xfer(RD | SP, 8'hFF);
		check(q, {6'h00, ims_pkg::SEL_CH1});
		check({6'h00, link.scl, link.sda}, 8'h03);
		// Pin reset in mid-run restores the default channel
		rstN <= 1'b0;
		repeat (20) @(posedge clk);
		check({6'h00, connCh1, connCh0}, 8'h01);
		check({6'h00, spareCh1, spareCh0}, 8'h00);
		rstN <= 1'b1;
		repeat (12) @(posedge clk);
		check({6'h00, connCh1, connCh0}, 8'h01);
		testDone();
	end
endmodule : i2c_master_selector_slave_port_bench
`default_nettype wire

// [testbench/ims_link_properties.sv]
// Checker on the upstream link wires between master end and slave port.
// Assumes clk samples the wires far faster than SCL; rstN is the pin.
`timescale 1ns/1ps
`default_nettype none
module ims_link_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic linkClk,
	input wire logic rstN,
	input wire logic mSdaOe,
	input wire logic dSdaOe,
	input wire logic scl,
	input wire logic sda
);
	logic       pSda;
	logic       pScl;
	logic       inTxn;
	logic [7:0] rises;
	wire        startSeen = pSda && !sda && scl && pScl;
	wire        stopSeen  = !pSda && sda && scl && pScl;

	// Wire history, open transaction, SCL rises since the last start
	always_ff @(posedge clk)
	begin
		pSda <= sda;
		pScl <= scl;
		inTxn <= (rst || stopSeen) ? 1'b0 : (inTxn || startSeen);
		rises <= (rst || startSeen) ? 8'h00 : rises + 8'(scl && !pScl);
	end

	property p_devStill;
		@(posedge clk) disable iff (rst) scl && pScl |-> $stable(dSdaOe);
	endproperty
	a_devStill: assert property (p_devStill)
		else $error("slave SDA moved while SCL high");

	property p_ackHeld;
		@(posedge clk) disable iff (rst) $rose(scl) && dSdaOe |-> dSdaOe [*8];
	endproperty
	a_ackHeld: assert property (p_ackHeld)
		else $error("slave low drive dropped in SCL high phase");

	property p_startMaster;
		@(posedge clk) disable iff (rst) startSeen |-> mSdaOe && !dSdaOe;
	endproperty
	a_startMaster: assert property (p_startMaster)
		else $error("start not made by the master");

	property p_stopMaster;
		@(posedge clk) disable iff (rst)
			stopSeen |-> $past(mSdaOe) && !$past(dSdaOe);
	endproperty
	a_stopMaster: assert property (p_stopMaster)
		else $error("stop not made by the master release");

	// Released lines must rest high once a stop is seen
	property p_idleHigh;
		@(posedge clk) disable iff (rst) stopSeen |=> (sda && scl) [*8];
	endproperty
	a_idleHigh: assert property (p_idleHigh)
		else $error("bus not high after stop");

	property p_devIdle;
		@(posedge clk) disable iff (rst) !inTxn |-> !dSdaOe;
	endproperty
	a_devIdle: assert property (p_devIdle)
		else $error("slave drives SDA outside a transaction");

	// Pin reset needs a few link edges to pass the synchroniser
	property p_resetQuiet;
		@(posedge linkClk) !rstN [*5] |-> !dSdaOe;
	endproperty
	a_resetQuiet: assert property (p_resetQuiet)
		else $error("slave drives SDA while held in reset");

	// Nine pulses a byte plus the stop's own SCL rise
	property p_ninePerByte;
		@(posedge clk) disable iff (rst) stopSeen |-> rises % 8'h09 == 8'h01;
	endproperty
	a_ninePerByte: assert property (p_ninePerByte)
		else $error("SCL pulse count not whole bytes");

	c_start: cover property (@(posedge clk) startSeen);
	c_devAck: cover property (@(posedge clk) $rose(scl) && dSdaOe);
	c_stop: cover property (@(posedge clk) stopSeen);
endmodule : ims_link_properties
`default_nettype wire
